// ===== fwsr_pkg.sv
package fwsr_pkg;

    // ----------------------------------------------------------------
    // widths and clock
    // ----------------------------------------------------------------
    localparam int FL_ADDR_W = 18;
    localparam int FL_DATA_W = 16;
    localparam int CLK_MHZ = 100;

    // ----------------------------------------------------------------
    // flash bus timing, least times in ns
    // ----------------------------------------------------------------
    localparam int T_SETUP_NS = 10;
    localparam int T_WE_LOW_NS = 35;
    localparam int T_RD_ACC_NS = 70;
    localparam int T_RECOV_NS = 20;

    // least time rounds up, never below one cycle
    function automatic int ns_to_cyc(input int ns);
        int c;
        c = (ns * CLK_MHZ + 999) / 1000;
        return (c < 1) ? 1 : c;
    endfunction : ns_to_cyc

    localparam logic [7:0] SETUP_CYC = 8'(ns_to_cyc(T_SETUP_NS));
    localparam logic [7:0] WE_LOW_CYC = 8'(ns_to_cyc(T_WE_LOW_NS));
    localparam logic [7:0] RD_ACC_CYC = 8'(ns_to_cyc(T_RD_ACC_NS));
    localparam logic [7:0] RECOV_CYC = 8'(ns_to_cyc(T_RECOV_NS));

    // ----------------------------------------------------------------
    // register map (byte addresses) and fields
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_WDATA = 8'h08;
    localparam logic [7:0] REG_RDATA = 8'h0c;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_POLL = 8'h14;
    localparam int CTRL_NOWAIT = 4;
    localparam int ST_BUSY = 0;
    localparam int ST_DONE = 1;
    localparam int ST_FAIL = 2;
    localparam int ST_READY = 3;
    localparam int ST_SUSP = 4;
    localparam int ST_ERASING = 5;

    // ----------------------------------------------------------------
    // operations and flash command codes
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_READ = 4'h0, OP_RESET = 4'h1, OP_PROGRAM = 4'h2, OP_CHIP_ERASE = 4'h3,
        OP_SECTOR_ERASE = 4'h4, OP_SUSPEND = 4'h5, OP_RESUME = 4'h6,
        OP_AUTOSELECT = 4'h7, OP_POLL = 4'h8
    } fwsr_op_t;

    localparam logic [17:0] UNLOCK1_ADDR = 18'h00555;
    localparam logic [17:0] UNLOCK2_ADDR = 18'h002aa;
    localparam logic [17:0] ANY_ADDR = 18'h00000;
    localparam logic [15:0] UNLOCK1_DATA = 16'h00aa;
    localparam logic [15:0] UNLOCK2_DATA = 16'h0055;
    localparam logic [15:0] CMD_PROGRAM = 16'h00a0;
    localparam logic [15:0] CMD_ERASE_SETUP = 16'h0080;
    localparam logic [15:0] CMD_CHIP_ERASE = 16'h0010;
    localparam logic [15:0] CMD_SECTOR_ERASE = 16'h0030;
    localparam logic [15:0] CMD_AUTOSELECT = 16'h0090;
    localparam logic [15:0] CMD_RESET = 16'h00f0;
    localparam logic [15:0] CMD_SUSPEND = 16'h00b0;
    localparam logic [15:0] CMD_RESUME = 16'h0030;

    // status bit positions on the data bus
    localparam int TOGGLE1_POS = 6;
    localparam int TIMEOUT_FAIL_POS = 5;

endpackage : fwsr_pkg

// ===== fwsr_bus_cycle.sv
`timescale 1ns/100ps

module fwsr_bus_cycle
#(
    parameter logic [7:0] SETUP_N = fwsr_pkg::SETUP_CYC,
    parameter logic [7:0] WE_N = fwsr_pkg::WE_LOW_CYC,
    parameter logic [7:0] ACC_N = fwsr_pkg::RD_ACC_CYC,
    parameter logic [7:0] RECOV_N = fwsr_pkg::RECOV_CYC
)
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // cycle request
    input wire logic start,
    input wire logic wr,
    input wire logic [fwsr_pkg::FL_ADDR_W-1:0] addr,
    input wire logic [fwsr_pkg::FL_DATA_W-1:0] wdata,
    output logic done,
    output logic [fwsr_pkg::FL_DATA_W-1:0] rdata,
    // flash pins
    output logic [fwsr_pkg::FL_ADDR_W-1:0] fl_addr,
    output logic [fwsr_pkg::FL_DATA_W-1:0] fl_dq_out,
    input wire logic [fwsr_pkg::FL_DATA_W-1:0] fl_dq_in,
    output logic fl_dq_oe,
    output logic fl_ce_n,
    output logic fl_oe_n,
    output logic fl_we_n
);
    import fwsr_pkg::*;

    typedef enum {CY_IDLE, CY_SETUP, CY_STROBE, CY_RECOV} fwsr_cy_t;
    fwsr_cy_t state;
    logic [7:0] cnt;
    logic wr_q;

    // one strobed cycle: setup, strobe low, recovery with ce and data held
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state <= CY_IDLE;
            cnt <= 8'h00;
            wr_q <= 1'b0;
            done <= 1'b0;
            rdata <= '0;
            fl_addr <= '0;
            fl_dq_out <= '0;
            fl_dq_oe <= 1'b0;
            fl_ce_n <= 1'b1;
            fl_oe_n <= 1'b1;
            fl_we_n <= 1'b1;
        end
        else
        begin
            done <= 1'b0;
            case (state)
                CY_IDLE:
                begin
                    if (start)
                    begin
                        wr_q <= wr;
                        fl_addr <= addr;
                        fl_dq_out <= wdata;
                        fl_dq_oe <= wr;
                        fl_ce_n <= 1'b0;
                        cnt <= SETUP_N - 8'h01;
                        state <= CY_SETUP;
                    end
                end
                CY_SETUP:
                begin
                    if (cnt == 8'h00)
                    begin
                        fl_we_n <= !wr_q;
                        fl_oe_n <= wr_q;
                        cnt <= (wr_q ? WE_N : ACC_N) - 8'h01;
                        state <= CY_STROBE;
                    end
                    else
                        cnt <= cnt - 8'h01;
                end
                CY_STROBE:
                begin
                    if (cnt == 8'h00)
                    begin
                        if (!wr_q)
                            rdata <= fl_dq_in; // sampled before oe rises
                        fl_we_n <= 1'b1; // data latches on this rising edge
                        fl_oe_n <= 1'b1;
                        cnt <= RECOV_N - 8'h01;
                        state <= CY_RECOV;
                    end
                    else
                        cnt <= cnt - 8'h01;
                end
                CY_RECOV:
                begin
                    if (cnt == 8'h00)
                    begin
                        fl_ce_n <= 1'b1;
                        fl_dq_oe <= 1'b0;
                        done <= 1'b1;
                        state <= CY_IDLE;
                    end
                    else
                        cnt <= cnt - 8'h01;
                end
                default: state <= CY_IDLE;
            endcase
        end
    end

endmodule : fwsr_bus_cycle

// ===== fwsr_host.sv
// Design decisions made here: the Wishbone register port and the placing of the registers.
`timescale 1ns/100ps

module fwsr_host
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // wishbone slave
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [7:0] wb_adr,
    input wire logic [31:0] wb_dat_w,
    input wire logic [3:0] wb_sel,
    output logic [31:0] wb_dat_r,
    output logic wb_ack,
    // flash pins
    output logic [fwsr_pkg::FL_ADDR_W-1:0] fl_addr,
    output logic [fwsr_pkg::FL_DATA_W-1:0] fl_dq_out,
    input wire logic [fwsr_pkg::FL_DATA_W-1:0] fl_dq_in,
    output logic fl_dq_oe,
    output logic fl_ce_n,
    output logic fl_oe_n,
    output logic fl_we_n,
    input wire logic ready_busy_n
);
    import fwsr_pkg::*;

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    typedef enum {H_IDLE, H_SEQ, H_POLL, H_FINAL, H_ABORT, H_FINISH} fwsr_state_t;
    fwsr_state_t state;
    fwsr_op_t op;
    logic nowait;
    logic [2:0] step;
    logic [1:0] phase;
    logic first_toggle_bit;
    logic in_flight;
    logic cyc_start;
    logic cyc_done;
    logic [FL_DATA_W-1:0] cyc_rdata;
    logic req_wr;
    logic [FL_ADDR_W-1:0] req_addr;
    logic [FL_DATA_W-1:0] req_data;
    logic [FL_ADDR_W-1:0] addr_reg;
    logic [FL_DATA_W-1:0] wdata_reg;
    logic [FL_DATA_W-1:0] rdata_reg;
    logic [7:0] poll_status;
    logic done_flag;
    logic fail_flag;
    logic suspended;
    logic erase_pending;
    logic set_done;
    logic set_fail;
    logic wb_req;
    logic wb_wr;
    logic go;
    logic [31:0] status_word;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // byte-lane merge for register writes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
            if (sel[i])
                r[i*8 +: 8] = nw[i*8 +: 8];
        return r;
    endfunction : merge

    // index of the last bus cycle of each command sequence
    function automatic logic [2:0] last_step(input fwsr_op_t o);
        case (o)
            OP_PROGRAM, OP_AUTOSELECT: return 3'h3;
            OP_CHIP_ERASE, OP_SECTOR_ERASE: return 3'h5;
            default: return 3'h0;
        endcase
    endfunction : last_step

    // one bus cycle of a command sequence as {write, address, data}
    function automatic logic [34:0] cmd_cycle(input fwsr_op_t o, input logic [2:0] s,
                                              input logic [17:0] a, input logic [15:0] d);
        case (o)
            OP_READ: return {1'b0, a, 16'h0000};
            OP_RESET: return {1'b1, ANY_ADDR, CMD_RESET};
            OP_SUSPEND: return {1'b1, ANY_ADDR, CMD_SUSPEND};
            OP_RESUME: return {1'b1, ANY_ADDR, CMD_RESUME};
            default:
            begin
                case (s)
                    3'h0: return {1'b1, UNLOCK1_ADDR, UNLOCK1_DATA};
                    3'h1: return {1'b1, UNLOCK2_ADDR, UNLOCK2_DATA};
                    3'h2:
                    begin
                        if (o == OP_PROGRAM)
                            return {1'b1, UNLOCK1_ADDR, CMD_PROGRAM};
                        if (o == OP_AUTOSELECT)
                            return {1'b1, UNLOCK1_ADDR, CMD_AUTOSELECT};
                        return {1'b1, UNLOCK1_ADDR, CMD_ERASE_SETUP};
                    end
                    3'h3:
                    begin
                        if (o == OP_PROGRAM)
                            return {1'b1, a, d};
                        if (o == OP_AUTOSELECT)
                            return {1'b0, a, 16'h0000};
                        return {1'b1, UNLOCK1_ADDR, UNLOCK1_DATA};
                    end
                    3'h4: return {1'b1, UNLOCK2_ADDR, UNLOCK2_DATA};
                    default:
                    begin
                        if (o == OP_CHIP_ERASE)
                            return {1'b1, UNLOCK1_ADDR, CMD_CHIP_ERASE};
                        return {1'b1, a, CMD_SECTOR_ERASE};
                    end
                endcase
            end
        endcase
    endfunction : cmd_cycle

    // ----------------------------------------------------------------
    // wishbone slave
    // ----------------------------------------------------------------
    assign wb_req = wb_cyc && wb_stb;
    assign wb_wr = wb_req && wb_we && wb_ack;
    assign status_word = {26'h0000000, erase_pending, suspended, ready_busy_n,
                          fail_flag, done_flag, state != H_IDLE || set_done}; // busy until done

    // suspend only over a sector erase, resume only from suspend
    assign go = wb_wr && (wb_adr == REG_CTRL) && wb_sel[0] && (state == H_IDLE)
                && (wb_dat_w[3:0] != OP_SUSPEND || (erase_pending && !suspended))
                && (wb_dat_w[3:0] != OP_RESUME || suspended);

    // ack one cycle after the request, read data registered with it
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wb_ack <= 1'b0;
            wb_dat_r <= 32'h00000000;
        end
        else
        begin
            wb_ack <= wb_req && !wb_ack;
            case (wb_adr)
                REG_CTRL: wb_dat_r <= {27'h0000000, nowait, op};
                REG_ADDR: wb_dat_r <= {14'h0000, addr_reg};
                REG_WDATA: wb_dat_r <= {16'h0000, wdata_reg};
                REG_RDATA: wb_dat_r <= {16'h0000, rdata_reg};
                REG_STATUS: wb_dat_r <= status_word;
                REG_POLL: wb_dat_r <= {24'h000000, poll_status};
                default: wb_dat_r <= 32'h00000000;
            endcase
        end
    end

    // address and program data registers
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            addr_reg <= '0;
            wdata_reg <= '0;
        end
        else if (wb_wr && wb_adr == REG_ADDR)
            addr_reg <= FL_ADDR_W'(merge({14'h0000, addr_reg}, wb_dat_w, wb_sel));
        else if (wb_wr && wb_adr == REG_WDATA)
            wdata_reg <= FL_DATA_W'(merge({16'h0000, wdata_reg}, wb_dat_w, wb_sel));
    end

    // sticky done and fail, write one to clear, a set wins
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            done_flag <= 1'b0;
            fail_flag <= 1'b0;
        end
        else
        begin
            if (set_done)
                done_flag <= 1'b1;
            else if (wb_wr && wb_adr == REG_STATUS && wb_sel[0] && wb_dat_w[ST_DONE])
                done_flag <= 1'b0;
            if (set_fail)
                fail_flag <= 1'b1;
            else if (wb_wr && wb_adr == REG_STATUS && wb_sel[0] && wb_dat_w[ST_FAIL])
                fail_flag <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // bus cycle request
    // ----------------------------------------------------------------
    // what the current state wants on the flash bus
    always_comb
    begin
        req_wr = 1'b0;
        req_addr = addr_reg; // status reads at the program or sector address
        req_data = '0;
        case (state)
            H_SEQ: {req_wr, req_addr, req_data} = cmd_cycle(op, step, addr_reg, wdata_reg);
            H_ABORT:
            begin
                req_wr = 1'b1;
                req_addr = ANY_ADDR;
                req_data = CMD_RESET;
            end
            default: req_wr = 1'b0;
        endcase
    end

    // launch one cycle per step and track it until done
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cyc_start <= 1'b0;
            in_flight <= 1'b0;
        end
        else
        begin
            cyc_start <= 1'b0;
            if (cyc_done)
                in_flight <= 1'b0;
            else if (!in_flight && (state == H_SEQ || state == H_POLL
                                    || state == H_FINAL || state == H_ABORT))
            begin
                cyc_start <= 1'b1;
                in_flight <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state <= H_IDLE;
            op <= OP_READ;
            nowait <= 1'b0;
            step <= 3'h0;
            phase <= 2'h0;
            first_toggle_bit <= 1'b0;
            rdata_reg <= '0;
            poll_status <= 8'h00;
            set_done <= 1'b0;
            set_fail <= 1'b0;
        end
        else
        begin
            set_done <= 1'b0;
            set_fail <= 1'b0;
            case (state)
                H_IDLE:
                begin
                    if (go)
                    begin
                        op <= fwsr_op_t'(wb_dat_w[3:0]);
                        nowait <= wb_dat_w[CTRL_NOWAIT];
                        step <= 3'h0;
                        phase <= 2'h0;
                        state <= (wb_dat_w[3:0] == OP_POLL) ? H_POLL : H_SEQ;
                    end
                end
                H_SEQ:
                begin
                    if (cyc_done)
                    begin
                        if (!req_wr)
                            rdata_reg <= cyc_rdata;
                        if (step != last_step(op))
                            step <= step + 3'h1;
                        else if (op == OP_AUTOSELECT)
                            state <= H_ABORT; // back to array reads
                        else if ((op == OP_PROGRAM || op == OP_CHIP_ERASE
                                  || op == OP_SECTOR_ERASE) && !nowait)
                            state <= H_POLL; // status valid at once
                        else
                            state <= H_FINISH;
                    end
                end
                H_POLL:
                begin
                    if (cyc_done)
                    begin
                        poll_status <= cyc_rdata[7:0];
                        first_toggle_bit <= cyc_rdata[TOGGLE1_POS];
                        phase <= phase + 2'h1;
                        if (phase[0])
                        begin
                            // compare the toggle bit over two reads
                            if (cyc_rdata[TOGGLE1_POS] == first_toggle_bit)
                                state <= H_FINAL;
                            else if (phase[1])
                            begin
                                set_fail <= 1'b1;
                                state <= H_ABORT; // still toggling
                            end
                            else if (!cyc_rdata[TIMEOUT_FAIL_POS])
                                phase <= 2'h0;
                        end
                    end
                end
                H_FINAL:
                begin
                    if (cyc_done)
                    begin
                        rdata_reg <= cyc_rdata; // the read after status settles
                        state <= H_FINISH;
                    end
                end
                H_ABORT:
                begin
                    if (cyc_done)
                        state <= H_FINISH;
                end
                H_FINISH:
                begin
                    set_done <= 1'b1;
                    state <= H_IDLE;
                end
                default: state <= H_IDLE;
            endcase
        end
    end

    // erase-in-progress and suspend tracking for the gate on suspend and resume
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            suspended <= 1'b0;
            erase_pending <= 1'b0;
        end
        else if (state == H_FINISH)
        begin
            if (op == OP_SECTOR_ERASE && nowait)
                erase_pending <= 1'b1;
            else if (op == OP_POLL || op == OP_RESET || op == OP_SECTOR_ERASE)
                erase_pending <= 1'b0;
            if (op == OP_SUSPEND)
                suspended <= 1'b1;
            else if (op == OP_RESUME || op == OP_RESET)
                suspended <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // flash bus engine
    // ----------------------------------------------------------------
    fwsr_bus_cycle u_cycle (
        .clk(clk),
        .nrst(nrst),
        .start(cyc_start),
        .wr(req_wr),
        .addr(req_addr),
        .wdata(req_data),
        .done(cyc_done),
        .rdata(cyc_rdata),
        .fl_addr(fl_addr),
        .fl_dq_out(fl_dq_out),
        .fl_dq_in(fl_dq_in),
        .fl_dq_oe(fl_dq_oe),
        .fl_ce_n(fl_ce_n),
        .fl_oe_n(fl_oe_n),
        .fl_we_n(fl_we_n)
    );

endmodule : fwsr_host

// ===== fwsr_flash_model.sv
`timescale 1ns/100ps

module fwsr_flash_model
(
    // flash pins
    input wire logic [17:0] fl_addr,
    input wire logic [15:0] fl_dq_out,
    input wire logic fl_ce_n,
    input wire logic fl_oe_n,
    input wire logic fl_we_n,
    output logic [15:0] fl_dq_in,
    output logic ready_busy_n
);
    logic [15:0] mem [logic [17:0]];
    logic [23:0] cmd = 24'h0;
    logic [15:0] q = 16'h0;
    logic [15:0] pd = 16'h0;
    logic tog = 1'b0;
    logic er = 1'b0;
    logic bad = 1'b0;
    logic susp = 1'b0;
    int left = 0;
    // open-drain line: pulled low while busy, pull-up otherwise
    assign ready_busy_n = (left > 0 && !susp) ? 1'b0 : 1'b1;
    // a released bus shows the inverse of the last word
    assign fl_dq_in = fl_oe_n ? ~q : q;
    // commands latch on the write strobe rising edge, upper byte ignored
    always @(posedge fl_we_n)
    begin
        if (!fl_ce_n && cmd == 24'haa55a0 && left == 0)
        begin
            bad = mem.exists(fl_addr) && |(fl_dq_out & ~mem[fl_addr]);
            if (!bad)
                mem[fl_addr] = fl_dq_out;
            pd = fl_dq_out;
            er = 1'b0;
            left = bad ? 99 : 2;
        end
        else if (!fl_ce_n && cmd == 24'h80aa55 && left == 0)
        begin
            mem.delete(fl_addr);
            er = 1'b1;
            left = 2;
        end
        else if (!fl_ce_n && fl_dq_out[7:0] == 8'hf0)
            left = 0;
        else if (!fl_ce_n && fl_dq_out[7:0] == 8'hb0 && er && left > 0)
            susp = 1'b1;
        else if (!fl_ce_n && fl_dq_out[7:0] == 8'h30 && susp)
            susp = 1'b0;
        cmd = {cmd[15:0], fl_dq_out[7:0]};
    end
    // status while busy, array data once done
    always @(negedge fl_oe_n)
    begin
        if (left > 0 && !susp)
        begin
            tog = ~tog;
            q = {8'h00, er ? 1'b0 : ~pd[7], tog, bad, 2'b00, er & tog, 2'b00};
            left = left - 1;
        end
        else
            q = mem.exists(fl_addr) ? mem[fl_addr] : 16'hffff;
    end
endmodule : fwsr_flash_model

// ===== fwsr_host_properties.sv
`timescale 1ns/100ps

module fwsr_host_props
(
    // watched ports
    input wire logic clk,
    input wire logic nrst,
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_ack,
    input wire logic [17:0] fl_addr,
    input wire logic [15:0] fl_dq_out,
    input wire logic fl_dq_oe,
    input wire logic fl_ce_n,
    input wire logic fl_oe_n,
    input wire logic fl_we_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // bus handshake and flash strobe shape
    AST_ACK_PULSE: assert property (wb_ack |=> !wb_ack)
        else $error("ack longer than one cycle");
    AST_ACK_CAUSE: assert property (wb_cyc && wb_stb && !wb_ack |=> wb_ack)
        else $error("ack late");
    AST_STROBES: assert property (!fl_we_n || !fl_oe_n |-> !fl_ce_n && (fl_we_n || fl_oe_n))
        else $error("strobe clash");
    AST_DQ_DIR: assert property ((!fl_we_n |-> fl_dq_oe) and (!fl_oe_n |-> !fl_dq_oe))
        else $error("dq direction wrong");
    AST_WE_WIDTH: assert property ($fell(fl_we_n) |-> !fl_we_n [*4] ##1 fl_we_n)
        else $error("write strobe width");
    AST_OE_WIDTH: assert property ($fell(fl_oe_n) |-> !fl_oe_n [*7] ##1 fl_oe_n)
        else $error("read strobe width");
    AST_CE_GAP: assert property ($rose(fl_ce_n) |-> fl_ce_n [*2])
        else $error("chip enable gap short");
    AST_SETUP: assert property ($fell(fl_ce_n) |-> fl_we_n && fl_oe_n ##1 !(fl_we_n && fl_oe_n))
        else $error("strobe setup wrong");
    AST_ADDR_HOLD: assert property (!fl_ce_n && $past(!fl_ce_n) |-> $stable(fl_addr))
        else $error("address moved in cycle");
    AST_CMD_UPPER: assert property (!fl_we_n && fl_addr inside {18'h555, 18'h2aa}
        |-> fl_dq_out[15:8] == 8'h00)
        else $error("command upper byte set");
    // main scenarios
    COV_WRITE: cover property ($fell(fl_we_n));
    COV_READ: cover property ($fell(fl_oe_n));
    COV_ACK: cover property (wb_ack);
endmodule : fwsr_host_props

bind fwsr_host fwsr_host_props chk_u (.clk, .nrst, .wb_cyc, .wb_stb, .wb_ack, .fl_addr,
    .fl_dq_out, .fl_dq_oe, .fl_ce_n, .fl_oe_n, .fl_we_n);

// ===== test_fwsr_host.sv
`timescale 1ns/100ps

module test_fwsr_host;
    import fwsr_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [31:0] wb_dat_w = 32'h0;
    logic [31:0] wb_dat_r, q;
    logic wb_ack, oe, ce, rd, we, rb;
    logic [17:0] fa, a;
    logic [15:0] fo, fi, d;
    int n_errors = 0;
    int checks_done = 0;
    // clock
    initial forever #5 clk = ~clk;
    fwsr_host dut_u (.clk, .nrst, .wb_cyc, .wb_stb, .wb_we, .wb_adr, .wb_dat_w, .wb_sel(4'hf),
        .wb_dat_r, .wb_ack, .fl_addr(fa), .fl_dq_out(fo), .fl_dq_in(fi), .fl_dq_oe(oe),
        .fl_ce_n(ce), .fl_oe_n(rd), .fl_we_n(we), .ready_busy_n(rb));
    fwsr_flash_model mdl_u (.fl_addr(fa), .fl_dq_out(fo), .fl_ce_n(ce), .fl_oe_n(rd),
        .fl_we_n(we), .fl_dq_in(fi), .ready_busy_n(rb));
    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // one classic wishbone cycle, read data left in q
    task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] dw);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= ad;
        wb_dat_w <= dw;
        do @(posedge clk); while (wb_ack !== 1'b1);
        q = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge clk);
    endtask : wb
    // poll status until the operation is over
    task automatic wait_idle();
        do wb(1'b0, REG_STATUS, 32'h0); while (q[ST_BUSY] !== 1'b0);
    endtask : wait_idle
    // idle status: flash ready, optional done flag
    function automatic logic [31:0] st_exp(input logic dn);
        return {28'h0, 1'b1, 1'b0, dn, 1'b0};
    endfunction : st_exp
    task automatic give_verdict();
        if (n_errors == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : give_verdict
    // a hang counts as a mismatch
    initial
    begin
        #300000;
        n_errors++;
        give_verdict();
    end
    // reset, register checks, random programs with read-back
    initial
    begin
        void'($urandom(32'h3e04));
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        wb(1'b0, REG_STATUS, 32'h0);
        chk(q, st_exp(1'b0));
        wb(1'b0, 8'h20, 32'h0);
        chk(q, 32'h0);
        for (int i = 0; i < 4; i++)
        begin
            a = {1'b1, 17'($urandom)};
            d = (i == 0) ? 16'hff7f : 16'($urandom);
            wb(1'b1, REG_ADDR, {14'h0, a});
            wb(1'b1, REG_WDATA, {16'h0, d});
            wb(1'b1, REG_CTRL, {28'h0, OP_PROGRAM});
            wait_idle();
            chk(q, st_exp(1'b1));
            wb(1'b0, REG_POLL, 32'h0);
            chk(q, {24'h0, d[7:0]});
            wb(1'b1, REG_STATUS, 32'h6);
            wb(1'b0, REG_STATUS, 32'h0);
            chk(q, st_exp(1'b0));
            wb(1'b1, REG_CTRL, {28'h0, OP_READ});
            wait_idle();
            wb(1'b1, REG_STATUS, 32'h6);
            wb(1'b0, REG_RDATA, 32'h0);
            chk(q, {16'h0, d});
        end
        // suspend and resume gating around a sector erase left running
        wb(1'b1, REG_CTRL, {28'h0, OP_SUSPEND});
        wait_idle();
        chk(q, st_exp(1'b0));
        wb(1'b1, REG_CTRL, {27'h0, 1'b1, OP_SECTOR_ERASE});
        wait_idle();
        chk(q, 32'h22);
        wb(1'b1, REG_CTRL, {28'h0, OP_RESUME});
        wait_idle();
        chk(q, 32'h22);
        wb(1'b1, REG_CTRL, {28'h0, OP_SUSPEND});
        wait_idle();
        chk(q, 32'h3a);
        wb(1'b1, REG_CTRL, {28'h0, OP_RESUME});
        wait_idle();
        chk(q, 32'h22);
        wb(1'b1, REG_CTRL, {28'h0, OP_POLL});
        wait_idle();
        chk(q, st_exp(1'b1));
        wb(1'b0, REG_RDATA, 32'h0);
        chk(q, 32'h0000ffff);
        // a fresh word, then a zero to one program that times out
        for (int k = 0; k < 2; k++)
        begin
            wb(1'b1, REG_WDATA, 32'(k));
            wb(1'b1, REG_CTRL, {28'h0, OP_PROGRAM});
            wait_idle();
            chk(q, (k == 0) ? 32'ha : 32'he);
            wb(1'b1, REG_STATUS, 32'h6);
        end
        give_verdict();
    end
endmodule : test_fwsr_host
